/* core/sptx_consts.vh */
// constants for the serial port transmit status block
`ifndef SPTX_CONSTS_VH
`define SPTX_CONSTS_VH
`define SPTX_ADDR_W 12
`define SPTX_OFS_STATUS 12'h000
`define SPTX_OFS_CONTROL 12'h004
`define SPTX_OFS_MASK 12'h008
`define SPTX_OFS_EVENT 12'h00C
`define SPTX_ST_IRQ 0
`define SPTX_ST_CNT_LO 1
`define SPTX_ST_CNT_HI 3
`define SPTX_ST_UNDERRUN 4
`define SPTX_ST_TXDONE 5
`define SPTX_CTL_TIM 0
`define SPTX_CTL_FLUSH 1
`define SPTX_CTL_CTRLMODE 2
`define SPTX_CTL_RST 3'h4
`define SPTX_CNT_W 3
`define SPTX_CNT_MAX 3'h4
`define SPTX_CNT_ZERO 3'h0
`define SPTX_CNT_ONE 3'h1
`define SPTX_XFER_BYTES 3'h1
`endif

/* core/sptx_sync3.v */
// three-stage input synchroniser with agreement check
`timescale 1ns/1ps
module sptx_sync3 #(
  parameter W = 1
) (
  ref_clk,
  srst,
  clk_en,
  din,
  dout_q
);
  input wire ref_clk;
  input wire srst;
  input wire clk_en;
  input wire [W-1:0] din;
  output reg [W-1:0] dout_q;
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;
  // first stage is read only by the second
  always @(posedge ref_clk) begin
    if (srst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else if (clk_en) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a bit changes only once stages two and three agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge ref_clk) begin
        if (srst) begin
          dout_q[i] <= 1'b0;
        end else if (clk_en && (s2_q[i] == s3_q[i])) begin
          dout_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule

/* core/sptx_status.v */
// transmit status flags, fifo count field and apb register slave
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "sptx_consts.vh"
module sptx_status #(
  parameter CNT_MAX = `SPTX_CNT_MAX
) (
  ref_clk,
  srst,
  clk_en,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  fifo_write,
  byte_loaded,
  byte_shifted,
  xfer_start,
  irq_q,
  transmit_interrupt_mode,
  transmit_fifo_flush,
  controller_mode
);
  input wire ref_clk;
  input wire srst;
  input wire clk_en;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [`SPTX_ADDR_W-1:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire fifo_write;
  input wire byte_loaded;
  input wire byte_shifted;
  input wire xfer_start;
  output reg irq_q;
  output reg transmit_interrupt_mode;
  output reg transmit_fifo_flush;
  output reg controller_mode;

  reg [2:0] ctl_q;
  reg [5:0] mask_q;
  reg done_q;
  reg underrun_q;
  reg summary_q;
  reg [`SPTX_CNT_W-1:0] cnt_q;
  reg [`SPTX_CNT_W-1:0] cnt_d;
  reg [`SPTX_CNT_W-1:0] bytes_q;
  reg [15:0] status_w;
  reg [31:0] rd_d;
  reg hit;
  wire [3:0] ev_s;
  wire ev_wr;
  wire ev_ld;
  wire ev_sh;
  wire ev_st;
  reg [3:0] ev_prev_q;
  wire acc;
  wire rd_status;
  wire dec;
  wire done_set;
  wire ur_set;
  wire irq_evt;
  wire [5:0] live;
  // next-value and decode signals
  reg [2:0] ctl_d;
  reg [5:0] mask_d;
  reg done_d;
  reg underrun_d;
  reg summary_d;
  reg [`SPTX_CNT_W-1:0] bytes_d;
  reg irq_d;
  wire [3:0] ev_rise;
  wire wr_ok;
  wire rd_take;
  wire [`SPTX_CNT_W:0] sent_next;
  wire sel_status;
  wire sel_control;
  wire sel_mask;
  wire sel_event;
  genvar g;

  // event strobes come from another part of the unit; treat them as pins
  sptx_sync3 #(.W(4)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .din({xfer_start, byte_shifted, byte_loaded, fifo_write}),
    .dout_q(ev_s)
  );

  // rising edges of the filtered levels become one-cycle events
  always @(posedge ref_clk) begin
    if (srst) begin
      ev_prev_q <= 4'h0;
    end else if (clk_en) begin
      ev_prev_q <= ev_s;
    end
  end
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_edge
      assign ev_rise[g] = ev_s[g] & ~ev_prev_q[g];
    end
  endgenerate
  // bit order follows the synchroniser's input concatenation;
  // a level held high counts once, at its rising edge
  assign ev_wr = ev_rise[0];
  assign ev_ld = ev_rise[1];
  assign ev_sh = ev_rise[2];
  assign ev_st = ev_rise[3];

  // completing edge of a transfer: pready was raised one cycle earlier
  assign acc = psel & penable & pready;
  // writes land on the completing edge
  assign wr_ok = acc & pwrite;
  // read data is captured on the first access edge, so a status read clears there;
  // clearing one edge later would lose an event that set a flag in between
  assign rd_take = psel & penable & ~pready & ~pwrite;
  assign rd_status = rd_take & sel_status;

  // register selects, decoded once for the read and the write paths
  assign sel_status = (paddr == `SPTX_OFS_STATUS);
  assign sel_control = (paddr == `SPTX_OFS_CONTROL);
  assign sel_mask = (paddr == `SPTX_OFS_MASK);
  assign sel_event = (paddr == `SPTX_OFS_EVENT);

  // decrement point depends on mode
  // the mode copy trails a control write by a cycle; harmless at event spacing
  assign dec = controller_mode ? ev_ld : ev_sh;

  // fifo count; a write on a full fifo overwrites so count holds
  always @* begin
    cnt_d = cnt_q;
    if (ev_wr && !dec && cnt_q != CNT_MAX[`SPTX_CNT_W-1:0]) begin
      cnt_d = cnt_q + `SPTX_CNT_ONE;
    end else if (dec && !ev_wr && cnt_q != `SPTX_CNT_ZERO) begin
      cnt_d = cnt_q - `SPTX_CNT_ONE;
    end else if (dec && ev_wr && cnt_q == `SPTX_CNT_ZERO) begin
      cnt_d = `SPTX_CNT_ONE;
    end
  end

  // start with nothing valid in the fifo
  assign ur_set = ev_st & (cnt_q == `SPTX_CNT_ZERO);
  // required bytes sent while tim selected
  // one spare bit so a wrapped shift counter cannot spoil the compare
  assign sent_next = {1'b0, bytes_q} + {1'b0, `SPTX_CNT_ONE};
  assign done_set = ctl_q[`SPTX_CTL_TIM] & ev_sh & (sent_next >= {1'b0, `SPTX_XFER_BYTES});
  // flush suppresses the underrun interrupt only
  assign irq_evt = done_set | (ur_set & ~ctl_q[`SPTX_CTL_FLUSH]);

  // next values of the sticky flags and the shifted-byte counter
  always @* begin
    bytes_d = bytes_q;
    done_d = done_q;
    underrun_d = underrun_q;
    summary_d = summary_q;
    // the shifted-byte counter restarts once tx done has been flagged
    if (done_set) begin
      bytes_d = `SPTX_CNT_ZERO;
    end else if (ev_sh) begin
      bytes_d = bytes_q + `SPTX_CNT_ONE;
    end
    if (done_set) begin
      done_d = 1'b1;
    end else if (rd_status) begin
      done_d = 1'b0;
    end
    // an event in the clearing cycle missed the captured word, so it must survive
    if (ur_set) begin
      underrun_d = 1'b1;
    end else if (rd_status) begin
      underrun_d = 1'b0;
    end
    // summary bit tracks any interrupt event
    if (irq_evt) begin
      summary_d = 1'b1;
    end else if (rd_status) begin
      summary_d = 1'b0;
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always @(posedge ref_clk) begin
    if (srst) begin
      done_q <= 1'b0;
      underrun_q <= 1'b0;
      summary_q <= 1'b0;
      cnt_q <= `SPTX_CNT_ZERO;
      bytes_q <= `SPTX_CNT_ZERO;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      bytes_q <= bytes_d;
      done_q <= done_d;
      underrun_q <= underrun_d;
      summary_q <= summary_d;
    end
  end

  // status word image
  always @* begin
    status_w = 16'h0000;
    status_w[`SPTX_ST_IRQ] = summary_q;
    status_w[`SPTX_ST_CNT_HI:`SPTX_ST_CNT_LO] = cnt_q;
    status_w[`SPTX_ST_UNDERRUN] = underrun_q;
    status_w[`SPTX_ST_TXDONE] = done_q;
  end

  // underrun only counts toward the line when flush is clear
  assign live = {done_q, underrun_q & ~ctl_q[`SPTX_CTL_FLUSH], 3'h0, summary_q};

  // read mux, address decode by if chain
  // unmapped offsets read as zero and raise pslverr
  always @* begin
    rd_d = 32'h00000000;
    hit = 1'b1;
    if (sel_status) begin
      rd_d = {16'h0000, status_w};
    end else if (sel_control) begin
      rd_d = {29'h00000000, ctl_q};
    end else if (sel_mask) begin
      rd_d = {26'h0000000, mask_q};
    end else if (sel_event) begin
      rd_d = {29'h00000000, bytes_q};
    end else begin
      hit = 1'b0;
    end
  end

  // next values of the writable registers; writes to status and the
  // shifted-byte counter are dropped, since both are read only
  always @* begin
    ctl_d = ctl_q;
    mask_d = mask_q;
    if (wr_ok) begin
      if (sel_control) begin
        ctl_d = pwdata[`SPTX_CTL_CTRLMODE:`SPTX_CTL_TIM];
      end else if (sel_mask) begin
        mask_d = pwdata[`SPTX_ST_TXDONE:`SPTX_ST_IRQ];
      end
    end
  end

  // apb slave: one wait state, pready is high in the second access cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctl_q <= `SPTX_CTL_RST;
      mask_q <= 6'h00;
    end else if (clk_en) begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= ~hit;
        prdata <= pwrite ? 32'h00000000 : rd_d;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
      ctl_q <= ctl_d;
      mask_q <= mask_d;
    end
  end

  // level interrupt: any unmasked summary or tx done bit, or underrun bit while flush is clear; the count bits never drive it
  always @* begin
    irq_d = |(live & mask_q);
  end

  // registered outputs; control copies trail a control write by one cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
      transmit_interrupt_mode <= 1'b0;
      transmit_fifo_flush <= 1'b0;
      controller_mode <= 1'b1;
    end else if (clk_en) begin
      irq_q <= irq_d;
      transmit_interrupt_mode <= ctl_q[`SPTX_CTL_TIM];
      transmit_fifo_flush <= ctl_q[`SPTX_CTL_FLUSH];
      controller_mode <= ctl_q[`SPTX_CTL_CTRLMODE];
    end
  end
endmodule

/* dv/sptx_status_monitor.sv */
// assertion checker for the transmit status block
`timescale 1ns/1ps
module sptx_status_monitor (
  input wire ref_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire transmit_interrupt_mode,
  input wire transmit_fifo_flush,
  input wire controller_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // a completed status read
  wire st_rd = pready & !pwrite & (paddr == 12'h000);
  // flush seen since the last status read; an underrun latched under flush has no summary bit
  logic flush_seen;
  always @(posedge ref_clk) flush_seen <= srst ? 1'b0 : st_rd ? transmit_fifo_flush : flush_seen | transmit_fifo_flush;
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_access: assert property (pready |-> psel && penable && $past(penable)) else $error("early pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_err_unmapped: assert property (pready && paddr > 12'h00C |-> pslverr) else $error("no pslverr");
  a_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_count_range: assert property (st_rd |-> prdata[3:1] <= 3'h4) else $error("count too big");
  a_done_summary: assert property (st_rd && prdata[5] |-> prdata[0]) else $error("no summary");
  a_under_summary: assert property (st_rd && prdata[4] && !flush_seen |-> prdata[0])
    else $error("no underrun summary");
  a_reset_ctl: assert property ($past(srst) |-> controller_mode && !transmit_interrupt_mode && !transmit_fifo_flush)
    else $error("bad control reset");
endmodule
bind sptx_status sptx_status_monitor u_mon (.*);

/* dv/testbench.sv */
// self-checking bench for the transmit status block
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] ev = 4'h0;
  logic pready, pslverr, irq_q, er, tim, flush, cmode;
  int err_count = 0, compares = 0, cyc = 0;
  sptx_status DUT (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_write(ev[0]), .byte_loaded(ev[1]), .byte_shifted(ev[2]), .xfer_start(ev[3]), .irq_q(irq_q),
    .transmit_interrupt_mode(tim), .transmit_fifo_flush(flush), .controller_mode(cmode));
  always #25 ref_clk = ~ref_clk;
  // watchdog, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one transfer; the idle edge at the end keeps psel from being driven twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // two-cycle event pulse (the input filter drops shorter ones), then quiet until it settles
  task pulse(input int k);
    ev[k] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ev[k] <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task ev_rd(input int k, input logic [31:0] e);
    pulse(k);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, e);
  endtask
  task t_regs();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h3F);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h004, 32'h3);
    @(posedge ref_clk);
    chk({cmode, flush, tim}, 32'h3);
  endtask
  task t_count();
    apb(1'b1, 12'h004, 32'h4);
    for (int i = 1; i <= 5; i++) ev_rd(0, (i > 4 ? 4 : i) << 1);
    ev_rd(1, 32'h6);
    ev_rd(2, 32'h6);
    apb(1'b1, 12'h004, 32'h0);
    ev_rd(1, 32'h6);
    ev_rd(2, 32'h4);
    ev_rd(2, 32'h2);
    ev_rd(2, 32'h0);
    ev_rd(2, 32'h0);
  endtask
  task t_under();
    apb(1'b1, 12'h008, 32'h31);
    pulse(3);
    chk(irq_q, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h11);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(irq_q, 32'h0);
    apb(1'b1, 12'h004, 32'h2);
    pulse(3);
    chk(irq_q, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h10);
  endtask
  task t_done();
    apb(1'b1, 12'h004, 32'h1);
    pulse(2);
    chk(irq_q, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h21);
    apb(1'b1, 12'h004, 32'h0);
    ev_rd(2, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h1);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    t_count();
    t_under();
    t_done();
    report_and_stop();
  end
endmodule
